// ### hw/aprr_routing_regs.sv
// analog path routing select registers behind an axi4-lite slave
//
// How it works
// - a write with bit 7 clear loads bits 6..0 into the input routing register.
// - a write with bit 7 set loads the output routing register, whose bit 6 reads 0.
// - input bit 6 loops the headset input to the headset output, reset 0.
// - input bit 5 loops the handset input to the handset output, reset 0.
// - input bit 4 feeds the caller-id input to the adc, reset 0.
// - input bit 3 feeds the line input to the adc, reset 0.
// - input bit 2 feeds the microphone to the adc, reset 0.
// - input bit 1 feeds the handset input to the adc, reset 0.
// - input bit 0 feeds the headset input to the adc, reset 0.
// - output bit 5 routes sidetone to the headset output, reset 0.
// - output bit 4 routes sidetone to the handset output, reset 0.
// - output bit 3 feeds the dac to the speaker driver, reset 0.
// - output bit 2 feeds the dac to the line driver, reset 0.
// - output bit 1 feeds the dac to the handset driver, reset 0.
// - output bit 0 feeds the dac to the headset driver, reset 0.
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "aprr_consts.svh"

module aprr_routing_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire aprr_pkg::aprr_addr_t s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire aprr_pkg::aprr_word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire aprr_pkg::aprr_addr_t s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output aprr_pkg::aprr_word_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // input path switch enables
  output logic headset_loop_through,
  output logic handset_loop_through,
  output logic callerid_to_adc_select,
  output logic line_in_to_adc_select,
  output logic microphone_to_adc_select,
  output logic handset_in_to_adc_select,
  output logic headset_in_to_adc_select,
  // output path switch enables
  output logic sidetone_to_headset_select,
  output logic sidetone_to_handset_select,
  output logic dac_to_speaker_select,
  output logic dac_to_line_out_select,
  output logic dac_to_handset_out_select,
  output logic dac_to_headset_out_select
);
  import aprr_pkg::*;

  aprr_byte_t inSel_r;
  aprr_byte_t outSel_r;
  logic awHeld_r;
  logic wHeld_r;
  aprr_addr_t awAddr_r;
  aprr_word_t wData_r;
  logic [3:0] wStrb_r;
  logic doWrite;
  logic wrOk;
  aprr_byte_t wByte;
  logic awHeld_nxt;
  logic wHeld_nxt;
  logic bValid_nxt;
  logic rValid_nxt;

  function automatic logic addrKnown(input aprr_addr_t a);
    return a == `APRR_OFF_PATH || a == `APRR_OFF_INPUT || a == `APRR_OFF_OUTPUT;
  endfunction

  // write address and data are held until both have arrived
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
    end else if (doWrite) begin
      awHeld_r <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_r <= 1'b1;
      awAddr_r <= s_axi_awaddr;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wHeld_r <= 1'b0;
      wData_r <= '0;
      wStrb_r <= '0;
    end else if (doWrite) begin
      wHeld_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_r <= 1'b1;
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
    end
  end

  // next-state copies let the ready outputs come from flops with unchanged timing
  always_comb begin
    awHeld_nxt = awHeld_r;
    wHeld_nxt = wHeld_r;
    bValid_nxt = s_axi_bvalid;
    if (doWrite) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
      bValid_nxt = 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_nxt = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_nxt = 1'b1;
      end
      if (s_axi_bready) begin
        bValid_nxt = 1'b0;
      end
    end
  end

  // ready flops reset high: the bank is idle out of reset
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_awready <= !awHeld_nxt && !bValid_nxt;
      s_axi_wready <= !wHeld_nxt && !bValid_nxt;
    end
  end

  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign wrOk = addrKnown(awAddr_r);
  // only the low byte carries select bits
  assign wByte = aprr_byte_t'(wData_r);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `APRR_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrOk ? `APRR_RESP_OKAY : `APRR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // shared word: bit 7 picks the bank, as on the serial host port
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      inSel_r <= `APRR_RST_SEL;
    end else if (doWrite && wStrb_r[`APRR_STRB_LANE]) begin
      if ((awAddr_r == `APRR_OFF_PATH && !wByte[`APRR_BIT_BANK]) ||
          awAddr_r == `APRR_OFF_INPUT) begin
        inSel_r <= wByte & `APRR_IN_MASK;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      outSel_r <= `APRR_RST_SEL;
    end else if (doWrite && wStrb_r[`APRR_STRB_LANE]) begin
      // output bank load, reserved bit forced 0
      if ((awAddr_r == `APRR_OFF_PATH && wByte[`APRR_BIT_BANK]) ||
          awAddr_r == `APRR_OFF_OUTPUT) begin
        outSel_r <= wByte & `APRR_OUT_MASK;
      end
    end
  end

  // read side; path offset reads the input bank since bit 7 cannot steer a read
  always_comb begin
    rValid_nxt = s_axi_rvalid;
    if (s_axi_arvalid && s_axi_arready) begin
      rValid_nxt = 1'b1;
    end else if (s_axi_rready) begin
      rValid_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !rValid_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `APRR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addrKnown(s_axi_araddr) ? `APRR_RESP_OKAY : `APRR_RESP_SLVERR;
      if (s_axi_araddr == `APRR_OFF_OUTPUT) begin
        s_axi_rdata <= {24'h000000, outSel_r | `APRR_RD_OUT_FLAG};
      end else if (addrKnown(s_axi_araddr)) begin
        s_axi_rdata <= {24'h000000, inSel_r};
      end else begin
        s_axi_rdata <= '0;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // one flop per switch, no exclusion
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {headset_loop_through, handset_loop_through, callerid_to_adc_select,
       line_in_to_adc_select, microphone_to_adc_select, handset_in_to_adc_select,
       headset_in_to_adc_select} <= 7'h00;
      {sidetone_to_headset_select, sidetone_to_handset_select, dac_to_speaker_select,
       dac_to_line_out_select, dac_to_handset_out_select,
       dac_to_headset_out_select} <= 6'h00;
    end else begin
      headset_loop_through <= inSel_r[`APRR_IN_HEADSET_LOOP];
      handset_loop_through <= inSel_r[`APRR_IN_HANDSET_LOOP];
      callerid_to_adc_select <= inSel_r[`APRR_IN_CALLERID];
      line_in_to_adc_select <= inSel_r[`APRR_IN_LINE];
      microphone_to_adc_select <= inSel_r[`APRR_IN_MICROPHONE];
      handset_in_to_adc_select <= inSel_r[`APRR_IN_HANDSET];
      headset_in_to_adc_select <= inSel_r[`APRR_IN_HEADSET];
      sidetone_to_headset_select <= outSel_r[`APRR_OUT_SIDETONE_HEADSET];
      sidetone_to_handset_select <= outSel_r[`APRR_OUT_SIDETONE_HANDSET];
      dac_to_speaker_select <= outSel_r[`APRR_OUT_SPEAKER];
      dac_to_line_out_select <= outSel_r[`APRR_OUT_LINE];
      dac_to_handset_out_select <= outSel_r[`APRR_OUT_HANDSET];
      dac_to_headset_out_select <= outSel_r[`APRR_OUT_HEADSET];
    end
  end

  a_input_bank_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
    doWrite && wStrb_r[`APRR_STRB_LANE] && awAddr_r == `APRR_OFF_PATH && !wByte[`APRR_BIT_BANK]
    |=> inSel_r == ($past(wByte) & `APRR_IN_MASK) && $stable(outSel_r))
    else $error("input bank not loaded");
  a_output_bank_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
    doWrite && wStrb_r[`APRR_STRB_LANE] && awAddr_r == `APRR_OFF_PATH && wByte[`APRR_BIT_BANK]
    |=> outSel_r == ($past(wByte) & `APRR_OUT_MASK) && $stable(inSel_r))
    else $error("output bank not loaded");
  a_strobe_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    doWrite && !wStrb_r[`APRR_STRB_LANE] |=> $stable(inSel_r) && $stable(outSel_r))
    else $error("masked write changed a bank");
  a_unmapped_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    doWrite && !wrOk |=> $stable(inSel_r) && $stable(outSel_r))
    else $error("unmapped write changed a bank");
  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    outSel_r[7:6] == 2'b00)
    else $error("reserved output bit set");
  a_headset_loop: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ##1 headset_loop_through == $past(inSel_r[6]))
    else $error("headset loop mismatch");
  a_handset_loop: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(inSel_r[5]) |=> handset_loop_through)
    else $error("handset loop late");
  a_handset_release: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(inSel_r[5]) |=> !handset_loop_through)
    else $error("handset loop not released");
  a_adc_sources: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ##1 {callerid_to_adc_select, line_in_to_adc_select, microphone_to_adc_select,
    handset_in_to_adc_select, headset_in_to_adc_select} == $past(inSel_r[4:0]))
    else $error("adc source mismatch");
  a_sidetone_routes: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ##1 {sidetone_to_headset_select, sidetone_to_handset_select} == $past(outSel_r[5:4]))
    else $error("sidetone route mismatch");
  a_dac_routes: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ##1 {dac_to_speaker_select, dac_to_line_out_select, dac_to_handset_out_select,
    dac_to_headset_out_select} == $past(outSel_r[3:0]))
    else $error("dac route mismatch");
  a_write_answer: assert property (@(posedge sys_clk) disable iff (sys_rst)
    doWrite |=> s_axi_bvalid)
    else $error("write response missing");
  a_write_ready: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_axi_awready == (!awHeld_r && !s_axi_bvalid) && s_axi_wready == (!wHeld_r && !s_axi_bvalid))
    else $error("write ready out of step");
  a_read_answer: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data missing");
endmodule

// ### include/aprr_consts.svh
// constants for the analog path routing register bank
`ifndef APRR_CONSTS_SVH
`define APRR_CONSTS_SVH
`define APRR_ADDR_W 4
`define APRR_OFF_PATH 4'h0
`define APRR_OFF_INPUT 4'h4
`define APRR_OFF_OUTPUT 4'h8
`define APRR_BIT_BANK 7
`define APRR_BIT_RSVD 6
`define APRR_STRB_LANE 0
`define APRR_IN_HEADSET_LOOP 6
`define APRR_IN_HANDSET_LOOP 5
`define APRR_IN_CALLERID 4
`define APRR_IN_LINE 3
`define APRR_IN_MICROPHONE 2
`define APRR_IN_HANDSET 1
`define APRR_IN_HEADSET 0
`define APRR_OUT_SIDETONE_HEADSET 5
`define APRR_OUT_SIDETONE_HANDSET 4
`define APRR_OUT_SPEAKER 3
`define APRR_OUT_LINE 2
`define APRR_OUT_HANDSET 1
`define APRR_OUT_HEADSET 0
`define APRR_RD_OUT_FLAG 8'h80
`define APRR_RST_SEL 8'h00
`define APRR_IN_MASK 8'h7f
`define APRR_OUT_MASK 8'h3f
`define APRR_RESP_OKAY 2'b00
`define APRR_RESP_SLVERR 2'b10
`endif

// ### include/aprr_pkg.sv
// types for the analog path routing register bank
package aprr_pkg;
  typedef logic [7:0] aprr_byte_t;
  typedef logic [3:0] aprr_addr_t;
  typedef logic [31:0] aprr_word_t;
endpackage

// ### verif/testbench.sv
// self-checking bench for the analog path routing register bank
`timescale 1ns/1ps
`include "aprr_consts.svh"

module testbench;
  import aprr_pkg::*;
  logic sysClk = 1'b0;
  logic sysRst = 1'b1;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid;
  aprr_addr_t awAddr = '0, arAddr = '0;
  aprr_word_t wData = '0, rData;
  logic [3:0] wStrb = 4'h0;
  logic [1:0] bResp, rResp;
  logic [12:0] sw;
  logic [6:0] inReg = 7'h00;
  logic [5:0] outReg = 6'h00;
  logic [1:0] wq[$];
  logic [33:0] rq[$];
  int n_fail = 0;
  int compares = 0;

  always #12.5 sysClk = ~sysClk;

  aprr_routing_regs i_aprr_routing_regs (
    .sys_clk(sysClk), .sys_rst(sysRst),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_araddr(arAddr),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .headset_loop_through(sw[12]), .handset_loop_through(sw[11]),
    .callerid_to_adc_select(sw[10]), .line_in_to_adc_select(sw[9]),
    .microphone_to_adc_select(sw[8]), .handset_in_to_adc_select(sw[7]),
    .headset_in_to_adc_select(sw[6]), .sidetone_to_headset_select(sw[5]),
    .sidetone_to_handset_select(sw[4]), .dac_to_speaker_select(sw[3]),
    .dac_to_line_out_select(sw[2]), .dac_to_handset_out_select(sw[1]),
    .dac_to_headset_out_select(sw[0])
  );

  task automatic bad(string m);
    n_fail++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic cmp(logic [33:0] got, logic [33:0] exp, string m);
    compares++;
    if (got !== exp) bad(m);
  endtask

  // monitor: oldest note is matched against each response as it is taken
  always @(posedge sysClk) begin
    if (bValid === 1'b1 && bReady === 1'b1) begin
      if (wq.size() == 0) bad("write response without request");
      else cmp({32'h0, bResp}, {32'h0, wq.pop_front()}, "write response");
    end
    if (rValid === 1'b1 && rReady === 1'b1) begin
      if (rq.size() == 0) bad("read data without request");
      else cmp({rResp, rData}, rq.pop_front(), "read data");
    end
  end

  task automatic wr(aprr_addr_t a, aprr_word_t d, logic s);
    int n;
    logic ok;
    n = 0;
    ok = (a == `APRR_OFF_PATH || a == `APRR_OFF_INPUT || a == `APRR_OFF_OUTPUT);
    @(posedge sysClk);
    awValid <= 1'b1;
    wValid <= 1'b1;
    awAddr <= a;
    wData <= d;
    wStrb <= {3'b111, s};
    bReady <= 1'b1;
    wq.push_back(ok ? `APRR_RESP_OKAY : `APRR_RESP_SLVERR);
    // bit 7 only steers the shared word; the direct offsets ignore it
    if (ok && s) begin
      if (a == `APRR_OFF_OUTPUT || (a == `APRR_OFF_PATH && d[7])) outReg = d[5:0];
      else inReg = d[6:0];
    end
    do begin
      @(posedge sysClk);
      n++;
      if (awReady === 1'b1) awValid <= 1'b0;
      if (wReady === 1'b1) wValid <= 1'b0;
    end while ((awValid || wValid || bValid !== 1'b1) && n < 50);
    bReady <= 1'b0;
    if (n >= 50) bad("write timed out");
  endtask

  task automatic rd(aprr_addr_t a);
    int n;
    n = 0;
    @(posedge sysClk);
    arValid <= 1'b1;
    arAddr <= a;
    rReady <= 1'b1;
    case (a)
      `APRR_OFF_PATH, `APRR_OFF_INPUT: rq.push_back({`APRR_RESP_OKAY, 25'h0, inReg});
      `APRR_OFF_OUTPUT: rq.push_back({`APRR_RESP_OKAY, 24'h0, 2'b10, outReg});
      default: rq.push_back({`APRR_RESP_SLVERR, 32'h0});
    endcase
    do begin
      @(posedge sysClk);
      n++;
      if (arReady === 1'b1) arValid <= 1'b0;
    end while ((arValid || rValid !== 1'b1) && n < 50);
    rReady <= 1'b0;
    if (n >= 50) bad("read timed out");
  endtask

  // enables follow the registers one cycle late, so let two edges pass
  task automatic chkSw();
    repeat (2) @(posedge sysClk);
    #1;
    cmp({21'h0, sw}, {21'h0, inReg, outReg}, "switch enables");
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #500000;
    bad("watchdog expired");
    test_done();
  end

  initial begin
    void'($urandom(32'h3c8d));
    repeat (8) @(posedge sysClk);
    sysRst <= 1'b0;
    chkSw();
    rd(`APRR_OFF_PATH);
    rd(`APRR_OFF_OUTPUT);
    $display("test reset values done");
    for (int i = 0; i < 7; i++) begin
      wr(`APRR_OFF_PATH, 32'h1 << i, 1'b1);
      chkSw();
      wr(`APRR_OFF_PATH, 32'h80 | (32'h1 << i), 1'b1);
      chkSw();
      rd(`APRR_OFF_PATH);
      rd(`APRR_OFF_OUTPUT);
    end
    $display("test walking selects done");
    // random mixes of several enables, strobe and offset drawn too
    for (int i = 0; i < 40; i++) begin
      wr(aprr_addr_t'({$urandom_range(3, 0), 2'b00}), $urandom, 1'($urandom_range(1, 0)));
      chkSw();
      rd(aprr_addr_t'({$urandom_range(3, 0), 2'b00}));
    end
    $display("test random routing done");
    wr(4'hc, 32'hff, 1'b1);
    chkSw();
    rd(4'hc);
    $display("test unmapped offset done");
    wr(`APRR_OFF_INPUT, 32'h7f, 1'b1);
    wr(`APRR_OFF_OUTPUT, 32'h7f, 1'b1);
    chkSw();
    @(posedge sysClk);
    sysRst <= 1'b1;
    inReg = 7'h00;
    outReg = 6'h00;
    repeat (3) @(posedge sysClk);
    sysRst <= 1'b0;
    chkSw();
    rd(`APRR_OFF_INPUT);
    rd(`APRR_OFF_OUTPUT);
    $display("test mid-run reset done");
    test_done();
  end
endmodule
